//--- verilog/pmt_pkg.sv
// How it works
// - Software reads and writes the count and period registers at any time.
// - Any reset loads the count with zero and the period with all ones.
// - The timer runs while the run bit, control bit 2, is one.
// - Clearing the run bit stops the count.
// - Writing the count or control register clears prescaler and postscaler counters.
// - Any reset clears the prescaler and postscaler counters.
// - Writing the control register leaves the count unchanged.
// - Postscale field, bits 6 to 3, gives one output per N+1 matches.
// - Prescale field, bits 1 to 0: 00 divides by 1, 01 by 4, 1x by 64.
// - The prescaler is fed by the clock divided by four; each output increments the count.
// - On a match the count returns to zero at the next increment and postscaler advances.
// - The postscaler output sets the match flag in the flag register.
package pmt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 3;
  localparam logic [2:0]  ADDR_COUNT     = 3'h0;
  localparam logic [2:0]  ADDR_PERIOD    = 3'h1;
  localparam logic [2:0]  ADDR_CONTROL   = 3'h2;
  localparam logic [2:0]  ADDR_FLAG      = 3'h3;
  localparam logic [2:0]  ADDR_ENABLE    = 3'h4;
  localparam logic [2:0]  ADDR_CLEAR     = 3'h5;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          MATCH_BIT      = 1;
  localparam int          RUN_BIT        = 2;
  localparam logic [7:0]  COUNT_RST      = 8'h00;
  localparam logic [7:0]  PERIOD_RST     = 8'hff;
  localparam logic [6:0]  CONTROL_RST    = 7'h00;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [1:0]  INST_LAST      = 2'h3;
  localparam logic [5:0]  PRE_LAST_1     = 6'h00;
  localparam logic [5:0]  PRE_LAST_4     = 6'h03;
  localparam logic [5:0]  PRE_LAST_64    = 6'h3f;

  typedef struct packed {
    logic [3:0] post_sel;
    logic       run;
    logic [1:0] pre_sel;
  } pmt_ctrl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } pmt_req_t;

endpackage

//--- verilog/pmt_timer.sv
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module pmt_timer (
  input  wire             clk,
  input  wire             rst,
  input  wire             ce,
  input  pmt_pkg::pmt_req_t bus_req,
  output logic [7:0]      rd_data,
  output logic            irq
);
  import pmt_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]  count_q;
  logic [7:0]  count_d;
  logic [7:0]  period_q;
  logic [7:0]  period_d;
  pmt_ctrl_t   ctrl_q;
  pmt_ctrl_t   ctrl_d;
  logic [1:0]  inst_q;
  logic [5:0]  pre_q;
  logic [5:0]  pre_d;
  logic [3:0]  post_q;
  logic [3:0]  post_d;
  logic        flag_q;
  logic        flag_d;
  logic        en_q;
  logic        en_d;
  logic [7:0]  rd_data_q;
  logic [7:0]  rd_data_d;
  logic        irq_q;

  function automatic logic [5:0] pre_last(input logic [1:0] sel);
    logic [5:0] r;
    r = PRE_LAST_1;
    if (sel[1])
    begin
      r = PRE_LAST_64;
    end
    else if (sel[0])
    begin
      r = PRE_LAST_4;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_count   = bus_req.wr && bus_req.addr == ADDR_COUNT;
  wire wr_period  = bus_req.wr && bus_req.addr == ADDR_PERIOD;
  wire wr_control = bus_req.wr && bus_req.addr == ADDR_CONTROL;
  wire wr_enable  = bus_req.wr && bus_req.addr == ADDR_ENABLE;
  wire wr_clear   = bus_req.wr && bus_req.addr == ADDR_CLEAR;
  wire scaler_clr = wr_count || wr_control;
  wire inst_tick  = inst_q == INST_LAST;
  wire pre_hit    = pre_q == pre_last(ctrl_q.pre_sel);
  wire step       = ctrl_q.run && inst_tick && !scaler_clr;
  wire inc        = step && pre_hit;
  wire match      = count_q == period_q;
  wire post_out   = inc && match && post_q == ctrl_q.post_sel;
  wire flag_clr   = wr_clear && bus_req.wdata[MATCH_BIT];

  // ----------------------------------------------------------------
  // Next values
  // ----------------------------------------------------------------
  // Prescaler counts instruction ticks while running
  assign pre_d = scaler_clr ? 6'h00 :
                 !step      ? pre_q :
                 pre_hit    ? 6'h00 : pre_q + 6'h01;

  assign count_d = wr_count ? bus_req.wdata :
                   !inc     ? count_q :
                   match    ? COUNT_RST : count_q + 8'h01;

  assign post_d = scaler_clr ? 4'h0 :
                  !(inc && match) ? post_q :
                  post_out ? 4'h0 : post_q + 4'h1;

  assign period_d = wr_period ? bus_req.wdata : period_q;
  assign ctrl_d   = wr_control ? bus_req.wdata[6:0] : ctrl_q;
  assign en_d     = wr_enable ? bus_req.wdata[MATCH_BIT] : en_q;

  // Set wins over a clear in the same cycle
  assign flag_d = post_out || (flag_q && !flag_clr);

  assign rd_data_d = !bus_req.rd ? rd_data_q :
                     bus_req.addr == ADDR_COUNT   ? count_q :
                     bus_req.addr == ADDR_PERIOD  ? period_q :
                     bus_req.addr == ADDR_CONTROL ? {1'b0, ctrl_q} :
                     bus_req.addr == ADDR_FLAG    ? {6'h00, flag_q, 1'b0} :
                     bus_req.addr == ADDR_ENABLE  ? {6'h00, en_q, 1'b0} : 8'h00;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count_q  <= COUNT_RST;
      period_q <= PERIOD_RST;
      ctrl_q   <= CONTROL_RST;
      pre_q    <= 6'h00;
      post_q   <= 4'h0;
      inst_q   <= 2'h0;
    end
    else if (ce)
    begin
      count_q  <= count_d;
      period_q <= period_d;
      ctrl_q   <= ctrl_d;
      pre_q    <= pre_d;
      post_q   <= post_d;
      inst_q   <= inst_q + 2'h1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_q    <= 1'b0;
      en_q      <= 1'b0;
      rd_data_q <= 8'h00;
      irq_q     <= 1'b0;
    end
    else if (ce)
    begin
      flag_q    <= flag_d;
      en_q      <= en_d;
      rd_data_q <= rd_data_d;
      irq_q     <= flag_d && en_d;
    end
  end

  assign rd_data = rd_data_q;
  assign irq     = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  reset_values_a: assert property (
    @(posedge clk)
    rst |=> count_q == 8'h00 && period_q == 8'hff
  ) else $error("count or period wrong during reset");

  reset_scalers_a: assert property (
    @(posedge clk)
    rst |=> pre_q == 6'h00 && post_q == 4'h0
  ) else $error("scalers not cleared during reset");

  read_period_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && bus_req.rd && bus_req.addr == ADDR_PERIOD
    |=> rd_data == $past(period_q)
  ) else $error("period read back wrong");

  write_count_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && wr_count |=> count_q == $past(bus_req.wdata)
  ) else $error("count write not taken");

  run_step_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && ctrl_q.run && inst_tick && pre_hit && !scaler_clr && !match
    |=> count_q == $past(count_q) + 8'h01
  ) else $error("running timer did not increment");

  stopped_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && !ctrl_q.run && !wr_count |=> $stable(count_q) && $stable(pre_q)
  ) else $error("stopped timer moved");

  scaler_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && (wr_count || wr_control) |=> pre_q == 6'h00 && post_q == 4'h0
  ) else $error("scalers not cleared by write");

  control_keep_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && wr_control |=> count_q == $past(count_q)
  ) else $error("control write changed count");

  post_ratio_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && inc && match && post_q != ctrl_q.post_sel
    |=> post_q == $past(post_q) + 4'h1 && !flag_q || $past(flag_q)
  ) else $error("postscaler fired early");

  // Prescaler end points decoded apart from pre_last
  wire [5:0] chk_pre_last = ctrl_q.pre_sel[1] ? 6'h3f : (ctrl_q.pre_sel[0] ? 6'h03 : 6'h00);

  pre_ratio_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && step && pre_q == chk_pre_last
    |=> pre_q == 6'h00 && (count_q == $past(count_q) + 8'h01 || count_q == 8'h00)
  ) else $error("prescaler did not wrap at its ratio");

  pre_count_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && step && pre_q != chk_pre_last
    |=> pre_q == $past(pre_q) + 6'h01 && $stable(count_q)
  ) else $error("prescaler stepped wrongly");

  pre_bound_a: assert property (
    @(posedge clk) disable iff (rst)
    pre_q <= chk_pre_last
  ) else $error("prescaler beyond its ratio");

  bit_seven_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && bus_req.rd && bus_req.addr == ADDR_CONTROL |=> !rd_data[7]
  ) else $error("control bit 7 not zero");

  flag_set_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && post_out |=> flag_q
  ) else $error("flag not set by postscaler");

  irq_level_a: assert property (
    @(posedge clk) disable iff (rst)
    ce |=> irq == (flag_q && en_q)
  ) else $error("interrupt level mismatch");

  inst_rate_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && inc |-> inst_q == 2'h3 ##1 !inc
  ) else $error("increment off instruction tick");

  wrap_zero_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && inc && match && !wr_count |=> count_q == 8'h00
  ) else $error("count did not wrap on match");

  post_bound_a: assert property (
    @(posedge clk) disable iff (rst)
    post_q <= ctrl_q.post_sel
  ) else $error("postscaler beyond its ratio");

  post_fire_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && inc && match && post_q == ctrl_q.post_sel
    |=> post_q == 4'h0 && flag_q
  ) else $error("postscaler did not fire at its ratio");

  post_step_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && inc && !match |=> $stable(post_q)
  ) else $error("postscaler moved without a match");

  count_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && !inst_tick && !wr_count |=> $stable(count_q)
  ) else $error("count moved off instruction tick");

  write_period_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && wr_period |=> period_q == $past(bus_req.wdata)
  ) else $error("period write not taken");

  read_count_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && bus_req.rd && bus_req.addr == ADDR_COUNT
    |=> rd_data == $past(count_q)
  ) else $error("count read back wrong");

  read_control_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && bus_req.rd && bus_req.addr == ADDR_CONTROL
    |=> rd_data == {1'b0, $past(ctrl_q)}
  ) else $error("control read back wrong");

  write_control_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && wr_control |=> ctrl_q == $past(bus_req.wdata[6:0])
  ) else $error("control write not taken");

  read_flag_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && bus_req.rd && bus_req.addr == ADDR_FLAG
    |=> rd_data == {6'h00, $past(flag_q), 1'b0}
  ) else $error("flag read back wrong");

  flag_clear_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && flag_clr && !post_out |=> !flag_q
  ) else $error("flag not cleared by write");

  flag_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && flag_q && !flag_clr |=> flag_q
  ) else $error("flag dropped without a clear");

  write_enable_a: assert property (
    @(posedge clk) disable iff (rst)
    ce && wr_enable |=> en_q == $past(bus_req.wdata[MATCH_BIT])
  ) else $error("enable write not taken");

endmodule

//--- verification/tb_pmt_timer.sv
`timescale 1ns/100ps
module tb_pmt_timer;
  import pmt_pkg::*;

  logic        clk;
  logic        rst;
  logic        ce;
  pmt_req_t    bus_req;
  logic [7:0]  rd_data;
  logic        irq;
  logic        rnd_ce;
  logic [31:0] seed;
  logic [31:0] seed_ce;
  integer      n_fail;
  integer      cmp_count;
  integer      m_cnt, m_per, m_ctl, m_flg, m_en, m_div, m_pre, m_post, m_rd, m_irq;

  pmt_timer dut (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .rd_data(rd_data), .irq(irq));

  always #4 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ----------------------------------------------------------------
  // Reference model, stepped on the same edges as the design
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst)
  begin : model
    integer last;
    logic   set;
    if (rst)
    begin
      m_cnt = 0;
      m_per = 255;
      m_ctl = 0;
      m_flg = 0;
      m_en = 0;
      m_div = 0;
      m_pre = 0;
      m_post = 0;
      m_rd = 0;
      m_irq = 0;
    end
    else if (ce)
    begin
      last = m_ctl[1] ? 63 : (m_ctl[0] ? 3 : 0);
      set = 1'b0;
      if (bus_req.rd)
        m_rd = (bus_req.addr == ADDR_COUNT) ? m_cnt : (bus_req.addr == ADDR_PERIOD) ? m_per :
               (bus_req.addr == ADDR_CONTROL) ? m_ctl : (bus_req.addr == ADDR_FLAG) ? m_flg * 2 :
               (bus_req.addr == ADDR_ENABLE) ? m_en * 2 : 0;
      if (bus_req.wr && (bus_req.addr == ADDR_COUNT || bus_req.addr == ADDR_CONTROL))
      begin
        m_pre = 0;
        m_post = 0;
      end
      else if (m_ctl[2] && m_div == 3)
      begin
        m_pre = (m_pre == last) ? 0 : m_pre + 1;
        if (m_pre == 0)
        begin
          set = (m_cnt == m_per) && (m_post == m_ctl[6:3]);
          m_post = (m_cnt != m_per) ? m_post : (set ? 0 : m_post + 1);
          m_cnt = (m_cnt == m_per) ? 0 : (m_cnt + 1) % 256;
        end
      end
      m_div = (m_div + 1) % 4;
      if (bus_req.wr)
        case (bus_req.addr)
          ADDR_COUNT:   m_cnt = bus_req.wdata;
          ADDR_PERIOD:  m_per = bus_req.wdata;
          ADDR_CONTROL: m_ctl = bus_req.wdata & 8'h7f;
          ADDR_ENABLE:  m_en = bus_req.wdata[1];
          ADDR_CLEAR:   m_flg = (bus_req.wdata[1] && !set) ? 0 : m_flg;
          default:      ;
        endcase
      m_flg = set ? 1 : m_flg;
      m_irq = m_flg & m_en;
    end
  end

  always @(posedge clk)
    if (rnd_ce)
    begin
      seed_ce <= lfsr(seed_ce);
      ce <= seed_ce[3];
    end
    else
      ce <= 1'b1;

  always @(negedge clk)
    if (!rst)
      check({7'h00, irq}, m_irq[7:0]);

  // ----------------------------------------------------------------
  // Bus tasks and reporting
  // ----------------------------------------------------------------
  task check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask

  task rd(input logic [2:0] a);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    check(rd_data, m_rd[7:0]);
  endtask

  task read_all;
    for (int a = 0; a < 8; a++)
      rd(3'(a));
  endtask

  task results;
    $display("checks=%0d errors=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #600000;
    n_fail = n_fail + 1;
    results();
  end

  initial
  begin
    int s;
    int d;
    clk = 1'b0;
    rst = 1'b1;
    bus_req = '0;
    rnd_ce = 1'b0;
    seed = 32'h67c2f9cc;
    seed_ce = 32'h67c2f9cc;
    n_fail = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    read_all();
    wr(ADDR_CONTROL, 8'h80);
    wr(ADDR_FLAG, 8'hff);
    read_all();
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      wr(ADDR_PERIOD, seed[7:0]);
      wr(ADDR_COUNT, seed[15:8]);
      rd(ADDR_PERIOD);
      rd(ADDR_COUNT);
    end
    for (int p = 0; p < 4; p++)
    begin
      s = p * 5;
      d = (p == 0) ? 1 : ((p == 1) ? 4 : 64);
      wr(ADDR_ENABLE, {6'h00, p[0], 1'b0});
      wr(ADDR_PERIOD, 8'h02);
      wr(ADDR_CONTROL, {1'b0, s[3:0], 1'b1, p[1:0]});
      wr(ADDR_COUNT, 8'h01);
      repeat ((s + 1) * 3 * d + 8)
      begin
        rd(ADDR_COUNT);
        rd(ADDR_FLAG);
      end
      wr(ADDR_CLEAR, 8'h02);
      rd(ADDR_FLAG);
      wr(ADDR_CONTROL, {1'b0, s[3:0], 1'b0, p[1:0]});
      repeat (40) @(posedge clk);
      rd(ADDR_COUNT);
    end
    wr(ADDR_CONTROL, 8'h04);
    rnd_ce <= 1'b1;
    repeat (150)
    begin
      rd(ADDR_COUNT);
      rd(ADDR_FLAG);
    end
    @(posedge clk);
    rnd_ce <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    read_all();
    results();
  end
endmodule
